// *** design/oc_status_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oc_flags_defs.svh"
// Overcurrent status bank for twelve half-bridges
module oc_status_flags
  import oc_flags_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Comparator events, asynchronous, one per bridge
  input wire logic [11:0] high_oc_in,
  input wire logic [11:0] low_oc_in,
  // Other load-error flags (open load), same clock
  input wire logic open_load_any,
  // Decoded serial command
  input wire status_cmd_t cmd,
  // Read answer
  output logic rd_hit,
  output flag_byte_t rd_data,
  // Switch enables, low means forced off
  output logic [11:0] high_enable,
  output logic [11:0] low_enable,
  // Global load error
  output logic global_load_error
);
  // Two-stage synchronisers on comparator pins
  logic [23:0] ev_meta_reg;
  logic [23:0] ev_sync_reg;
  // Interleaved events: low at even, high at odd
  // Nets, since every bit has its own driver
  wire logic [23:0] ev_pair;
  // All flags, group g in bits 8g+7:8g
  wire logic [23:0] flag_all;
  logic [2:0] clr_pulse;
  logic [2:0] sel_hit;
  logic [4:0] sel_field;

  // Address field decode used by read and clear
  function automatic logic [2:0] group_decode(input logic [4:0] f);
    group_decode = {f == `ADDR_GRP3, f == `ADDR_GRP2, f == `ADDR_GRP1};
  endfunction : group_decode

  // Synchronise pins; metastability is kept off the flags
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
    end
    else
    begin
      ev_meta_reg <= {high_oc_in, low_oc_in};
      ev_sync_reg <= ev_meta_reg;
    end
  end

  assign sel_field = cmd.addr[`ADDR_SEL_HI:`ADDR_SEL_LO];
  assign sel_hit = cmd.valid ? group_decode(sel_field) : 3'h0;
  // Bit 7 of address selects clear over plain read
  assign clr_pulse = cmd.addr[`ADDR_OP_BIT] ? sel_hit : 3'h0;

  // One sticky byte per group
  genvar g;
  genvar b;
  generate
    // Pin index b is bridge b+1 on both sides
    for (b = 0; b < `BRIDGE_COUNT; b++)
    begin : g_pair
      // Low flag at even bit, high flag above it
      assign ev_pair[2*b] = ev_sync_reg[b];
      assign ev_pair[2*b+1] = ev_sync_reg[12+b];
      // Latched flag keeps the switch off
      assign low_enable[b] = ~flag_all[2*b];
      assign high_enable[b] = ~flag_all[2*b+1];
    end
    for (g = 0; g < `GROUP_COUNT; g++)
    begin : g_grp
      oc_group_flags u_grp (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .oc_event(ev_pair[8*g+7:8*g]),
        .clear_pulse(clr_pulse[g]),
        .flags(flag_all[8*g+7:8*g])
      );
    end
  endgenerate

  // Read answer: returns value before any clear in the same command
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= 8'h00;
      rd_hit <= 1'b0;
    end
    else
    begin
      rd_hit <= |sel_hit;
      case (sel_hit)
        3'h1: rd_data <= flag_all[7:0];
        3'h2: rd_data <= flag_all[15:8];
        3'h4: rd_data <= flag_all[23:16];
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // Global load error, drops when all flags cleared and no open load
  assign global_load_error = (|flag_all) | open_load_any;

  // Assertions
  // All checks sample on the one logic clock.
  // Pin events take three edges to reach a flag:
  // two synchroniser stages, then the sticky latch.

  // First edge after release sees an empty bank
  flag_reset_a: assert property (
    @(posedge sys_clk)
    $rose(arst_n) |-> flag_all == 24'h0)
    else $error("flags not zero after reset");

  // High-side event on bridge one forces it off
  high_off_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(high_oc_in[0]) |-> ##3 !high_enable[0])
    else $error("high switch not off after overcurrent");

  // Low-side event on bridge twelve latches and forces off
  low_off_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(low_oc_in[11]) |-> ##3 flag_all[22] && !low_enable[11])
    else $error("low switch not off after overcurrent");

  // A plain read never drops a flag
  read_keeps_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (cmd.valid && !cmd.addr[7]) |=> (flag_all & $past(flag_all)) == $past(flag_all))
    else $error("read altered flags");

  // Without a clear strobe no flag ever falls
  no_self_clear_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (clr_pulse == 3'h0) |=> (flag_all & $past(flag_all)) == $past(flag_all))
    else $error("flag cleared without command");

  // Clear of bridges five to eight empties that byte
  clear_grp2_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (clr_pulse[1] && ev_pair[15:8] == 8'h00) |=> flag_all[15:8] == 8'h00)
    else $error("group two clear failed");

  // Clear of bridges nine to twelve empties that byte
  clear_grp3_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (clr_pulse[2] && ev_pair[23:16] == 8'h00) |=> flag_all[23:16] == 8'h00)
    else $error("group three clear failed");

  // Clear of bridges one to four empties that byte
  clear_grp1_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (clr_pulse[0] && ev_pair[7:0] == 8'h00) |=> flag_all[7:0] == 8'h00)
    else $error("group one clear failed");

  // Event in the clear cycle survives; losing it would hide a fault
  set_wins_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (clr_pulse[2] && ev_pair[16]) |=> flag_all[16])
    else $error("event lost under clear");

  // Read of the first byte answers pre-command flags
  read_grp1_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    sel_hit[0] |=> rd_hit && rd_data == $past(flag_all[7:0]))
    else $error("group one read wrong");

  // Read of the second byte answers pre-command flags
  read_grp2_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    sel_hit[1] |=> rd_hit && rd_data == $past(flag_all[15:8]))
    else $error("group two read wrong");

  // Read of the third byte answers pre-command flags
  read_grp3_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    sel_hit[2] |=> rd_hit && rd_data == $past(flag_all[23:16]))
    else $error("group three read wrong");

  // Foreign address: no answer, zero data
  refused_cmd_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (cmd.valid && sel_hit == 3'h0) |=> !rd_hit && rd_data == 8'h00)
    else $error("foreign address answered");

  // No command, no answer strobe
  idle_answer_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    !cmd.valid |=> !rd_hit)
    else $error("answer without command");

  // Bridge five low flag sits at bit zero of its byte
  pair_order_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $rose(low_oc_in[4]) |-> ##3 flag_all[8])
    else $error("bridge five low flag not at bit 0");

  // Top high-side flag drives the top high-side enable
  high_map_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    high_enable[11] == !flag_all[23])
    else $error("bridge twelve high enable mismatch");

  // Load error follows every flag and open load
  load_err_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    global_load_error == ((flag_all != 24'h0) || open_load_any))
    else $error("load error mismatch");

  // Main scenarios worth seeing at least once
  clr_cov: cover property (@(posedge sys_clk) clr_pulse[0] && flag_all[7:0] != 8'h00);
  rd_cov: cover property (@(posedge sys_clk) sel_hit[1] && !cmd.addr[7]);
  ev_cov: cover property (@(posedge sys_clk) global_load_error && !open_load_any);
  set_clr_cov: cover property (@(posedge sys_clk) clr_pulse[2] && ev_pair[16]);
  refused_cov: cover property (@(posedge sys_clk) cmd.valid && sel_hit == 3'h0);
endmodule : oc_status_flags
`default_nettype wire

// *** design/oc_flags_defs.svh ***
// Functional notes
// - High-side overcurrent latches flag, switch off
// - Low-side overcurrent latches flag, switch off
// - Flags reset to zero, no error
// - Bridge pairs ascend: low D0, high D1
// - Bridges 5-8 byte at address 011 10
// - Bridges 9-12 byte at address 111 10
// - Address bit 7 set clears, else read
// - Only controller clear command returns flag; arst_n reset clears the flags too
// - Load error is OR of all flags
`ifndef OC_FLAGS_DEFS_SVH
`define OC_FLAGS_DEFS_SVH
// Address field (bits 6:2 of the address byte)
`define ADDR_GRP1 5'h16
`define ADDR_GRP2 5'h0e
`define ADDR_GRP3 5'h1e
// Address byte layout
`define ADDR_OP_BIT 7
`define ADDR_SEL_HI 6
`define ADDR_SEL_LO 2
// Flag reset value
`define FLAGS_RESET 8'h00
`define GROUP_COUNT 3
// Total bridges, and bits per status byte
`define BRIDGE_COUNT 12
`define GROUP_WIDTH 8
`endif

// *** design/oc_flags_pkg.sv ***
package oc_flags_pkg;
  // One serial command as seen by this block
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } status_cmd_t;
  // Flag byte of one group of four bridges
  typedef logic [7:0] flag_byte_t;
endpackage : oc_flags_pkg

// *** design/oc_group_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oc_flags_defs.svh"
// Sticky flags for one group of four bridges
module oc_group_flags
  import oc_flags_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Synchronised events, bit 2k low side, bit 2k+1 high side
  input wire logic [7:0] oc_event,
  // Clear strobe for this byte
  input wire logic clear_pulse,
  // Flag state
  output flag_byte_t flags
);
  // Per-bit sticky latch; a set in the clear cycle wins
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags <= `FLAGS_RESET;
    end
    else
    begin
      // Cleared only by command or by arst_n reset, never by the device itself
      flags <= (clear_pulse ? `FLAGS_RESET : flags) | oc_event;
    end
  end
endmodule : oc_group_flags
`default_nettype wire

// *** tb/status_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// Controller side: sends read or clear commands
module status_master
  import oc_flags_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Command to the bank
  output var status_cmd_t cmd,
  // Answer
  input wire logic rd_hit,
  input wire flag_byte_t rd_data
);
  // Idle until used
  initial cmd = '0;
  // One-cycle command, answer sampled after the next edge
  task automatic send(input logic clr, input logic [4:0] sel, output logic hit, output flag_byte_t data);
    @(posedge sys_clk);
    cmd <= {1'b1, clr, sel, 2'b01}; // Top address bit picks clear
    @(posedge sys_clk);
    cmd <= '0;
    #1;
    hit = rd_hit;
    data = rd_data;
  endtask : send
endmodule : status_master
`default_nettype wire

// *** tb/test_oc_status_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oc_flags_defs.svh"
// Bench for the overcurrent flag bank
module test_oc_status_flags;
  import oc_flags_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] high_oc_in = 12'h000;
  logic [11:0] low_oc_in = 12'h000;
  logic open_load_any = 1'b0;
  status_cmd_t cmd;
  logic rd_hit;
  flag_byte_t rd_data;
  logic [11:0] high_enable;
  logic [11:0] low_enable;
  logic global_load_error;
  int miscompares = 0;
  int n_tests = 0;
  // Group select fields
  logic [4:0] sel_tab [3] = '{`ADDR_GRP1, `ADDR_GRP2, `ADDR_GRP3};
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  oc_status_flags u_oc_status_flags (.sys_clk(sys_clk), .arst_n(arst_n), .high_oc_in(high_oc_in),
    .low_oc_in(low_oc_in), .open_load_any(open_load_any), .cmd(cmd), .rd_hit(rd_hit),
    .rd_data(rd_data), .high_enable(high_enable), .low_enable(low_enable),
    .global_load_error(global_load_error));
  status_master u_status_master (.sys_clk(sys_clk), .cmd(cmd), .rd_hit(rd_hit), .rd_data(rd_data));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Report and stop
  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // One command, answer compared
  task automatic access(input logic clr, input logic [4:0] sel, input logic hx, input flag_byte_t dx);
    logic hit;
    flag_byte_t data;
    u_status_master.send(clr, sel, hit, data);
    check(hit, hx);
    check(data, dx);
  endtask : access
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int g = 0; g < 3; g++)
      access(1'b0, sel_tab[g], 1'b1, 8'h00);
    check({high_enable, low_enable, global_load_error}, 25'h1fffffe);
    // Every switch in turn: latch, read, clear
    for (int i = 0; i < 24; i++)
    begin
      @(posedge sys_clk);
      if (i % 2)
        high_oc_in[i / 2] <= 1'b1;
      else
        low_oc_in[i / 2] <= 1'b1;
      @(posedge sys_clk);
      high_oc_in <= 12'h000;
      low_oc_in <= 12'h000;
      // Pulse gone: flag must stay set
      repeat (8) @(posedge sys_clk);
      #1;
      check({high_enable, low_enable}, 24'(~(24'h1 << ((i % 2) * 12 + i / 2))));
      check(global_load_error, 1'b1);
      access(1'b0, sel_tab[i / 8], 1'b1, 8'h01 << (i % 8));
      access(1'b1, sel_tab[i / 8], 1'b1, 8'h01 << (i % 8));
      access(1'b0, sel_tab[i / 8], 1'b1, 8'h00);
      check({high_enable, low_enable, global_load_error}, 25'h1fffffe);
    end
    // Address outside the bank is ignored
    access(1'b1, 5'h01, 1'b0, 8'h00);
    // Event meets a clear of its byte: set wins
    @(posedge sys_clk);
    low_oc_in[8] <= 1'b1;
    @(posedge sys_clk);
    low_oc_in <= 12'h000;
    access(1'b1, `ADDR_GRP3, 1'b1, 8'h00);
    access(1'b1, `ADDR_GRP3, 1'b1, 8'h01);
    access(1'b0, `ADDR_GRP3, 1'b1, 8'h00);
    // Reset in mid-run drops a latched flag
    @(posedge sys_clk);
    high_oc_in[0] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(high_enable[0], 1'b0);
    high_oc_in[0] <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(high_enable[0], 1'b1);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    access(1'b0, `ADDR_GRP1, 1'b1, 8'h00);
    check(global_load_error, 1'b0);
    @(posedge sys_clk);
    open_load_any <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(global_load_error, 1'b1);
    end_sim();
  end
endmodule : test_oc_status_flags
`default_nettype wire
